// ---- design/gdf_fault_manager.sv ----
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module gdf_fault_manager
    import gdf_pkg::*;
#(
    parameter int RETRY_COUNT = RETRY_CYCLES,
    parameter int DEG_UNIT = DEG_STEP_CYCLES
)(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire gdf_pkg::gdf_detect_type detect,
    input wire logic [5:0] fet_on,
    input wire logic [5:0] fet_vds_level,
    input wire logic enable_pin,
    output logic fault_indicator_n_o,
    output logic fault_indicator_n_oe,
    output logic shutdown_mode,
    output gdf_pkg::gdf_power_type power,
    output logic pump_buck_hiz
);
    import gdf_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;

    // The reset is released through two stages to avoid metastability.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic clear_q;
    logic ack_q;
    logic [31:0] status_w;
    logic [31:0] outs_w;
    logic [31:0] raw_w;
    logic wr_ctrl;
    logic bus_req;

    assign bus_req = (avs_read || avs_write) && !ack_q;
    assign wr_ctrl = avs_write && ack_q && (avs_address == ADDR_CTRL);

    // Every access is answered one cycle after it is seen.
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            avs_response <= BUS_OK;
        end
        else
        begin
            ack_q <= bus_req;
            avs_waitrequest <= !bus_req;
            avs_response <= BUS_OK;
            if (avs_read && !ack_q)
            begin
                case (avs_address)
                    ADDR_CTRL: avs_readdata <= ctrl_q;
                    ADDR_STATUS: avs_readdata <= status_w;
                    ADDR_RAW: avs_readdata <= raw_w;
                    ADDR_OUTS: avs_readdata <= outs_w;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register; the clear bit never stores.
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            ctrl_q <= CTRL_RESET;
        else if (wr_ctrl)
        begin
            ctrl_q <= avs_writedata;
            ctrl_q[CTRL_CLR_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            clear_q <= 1'b0;
        else
            clear_q <= wr_ctrl && avs_writedata[CTRL_CLR_BIT];
    end

    logic uv_off;
    logic ov_off;
    logic puv_off;
    gdf_oc_mode_type oc_mode;
    logic pull_low_sel;
    logic [3:0] th_sel;
    logic [3:0] deg_sel;

    assign uv_off = ctrl_q[CTRL_UVOFF_BIT];
    assign ov_off = ctrl_q[CTRL_OVOFF_BIT];
    assign puv_off = ctrl_q[CTRL_PUVOFF_BIT];
    assign oc_mode = gdf_oc_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign pull_low_sel = ctrl_q[CTRL_PD_BIT];
    assign th_sel = ctrl_q[CTRL_TH_LSB +: 4];
    assign deg_sel = ctrl_q[CTRL_DEG_LSB +: 4];

    // ****************************************************************
    // Clear sources
    // ****************************************************************
    logic en_prev_q;
    logic clr_evt;

    // Rising edge on the enable pin ends a low pulse.
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            en_prev_q <= 1'b1;
        else
            en_prev_q <= enable_pin;
    end

    assign clr_evt = clear_q || (enable_pin && !en_prev_q);

    // ****************************************************************
    // Overcurrent deglitch per transistor
    // ****************************************************************
    logic [5:0] oc_hit;
    logic [19:0] deg_limit;

    assign deg_limit = 20'((32'(deg_sel) + 1) * DEG_UNIT);

    // The threshold is applied by the comparator outside this block.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FETS; gi++)
        begin : g_deg
            logic [19:0] cnt_q;
            always_ff @(posedge clock or negedge rst_n_q)
            begin
                if (!rst_n_q)
                    cnt_q <= 20'h0_0000;
                else if (!(fet_on[gi] && fet_vds_level[gi]))
                    cnt_q <= 20'h0_0000;
                else if (cnt_q <= deg_limit)
                    cnt_q <= cnt_q + 20'h0_0001;
            end
            assign oc_hit[gi] = cnt_q > deg_limit;
        end
    endgenerate

    logic oc_any;
    logic oc_active;
    assign oc_any = |oc_hit;
    assign oc_active = oc_any && (oc_mode != OC_IGNORE);

    // ****************************************************************
    // Retry sequencer
    // ****************************************************************
    gdf_retry_state_type rs_q;
    logic [31:0] rcnt_q;
    logic retry_go;

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rs_q <= RS_IDLE;
            rcnt_q <= 32'h0000_0000;
        end
        else
        begin
            case (rs_q)
                RS_IDLE:
                    if (oc_active && oc_mode == OC_RETRY)
                    begin
                        rs_q <= RS_WAIT;
                        rcnt_q <= 32'h0000_0000;
                    end
                RS_WAIT:
                    if (rcnt_q >= 32'(RETRY_COUNT - 1))
                        rs_q <= RS_IDLE;
                    else
                        rcnt_q <= rcnt_q + 32'h0000_0001;
                default: rs_q <= RS_IDLE;
            endcase
        end
    end

    assign retry_go = (rs_q == RS_WAIT) && (rcnt_q >= 32'(RETRY_COUNT - 1));

    // ****************************************************************
    // Status latches
    // ****************************************************************
    logic uv_st_q;
    logic ov_st_q;
    logic puv_st_q;
    logic oc_st_q;
    logic [5:0] fet_st_q;

    // supply UV bit; set wins over clear
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            uv_st_q <= 1'b0;
        else if (detect.supply_uv)
            uv_st_q <= 1'b1;
        else if (clr_evt)
            uv_st_q <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            ov_st_q <= 1'b0;
        else if (detect.supply_ov)
            ov_st_q <= 1'b1;
        else if (clr_evt)
            ov_st_q <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            puv_st_q <= 1'b0;
        else if (detect.pump_uv)
            puv_st_q <= 1'b1;
        else if (clr_evt)
            puv_st_q <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            oc_st_q <= 1'b0;
            fet_st_q <= 6'h00;
        end
        else if (oc_active)
        begin
            oc_st_q <= 1'b1;
            fet_st_q <= fet_st_q | oc_hit;
        end
        else if (clr_evt || retry_go)
        begin
            oc_st_q <= 1'b0;
            fet_st_q <= 6'h00;
        end
    end

    // ****************************************************************
    // Driver gating for recoverable supply faults
    // ****************************************************************
    logic drv_hold_q;

    // drivers wait for a clear after OV or pump UV
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            drv_hold_q <= 1'b0;
        else if ((detect.supply_ov && !ov_off) ||
                 (detect.pump_uv && !puv_off))
            drv_hold_q <= 1'b1;
        else if (clr_evt)
            drv_hold_q <= 1'b0;
    end

    logic rail_ov_seen_q;
    // buck and pump enables held off until drive rail overvoltage recovers
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
            rail_ov_seen_q <= 1'b0;
        else
            rail_ov_seen_q <= detect.drive_rail_overvoltage;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic sup_uv_act;
    logic sup_ov_act;
    logic pump_act;
    logic fault_now;
    logic oc_stop;
    assign sup_uv_act = detect.supply_uv && !uv_off;
    assign sup_ov_act = detect.supply_ov && !ov_off;
    assign pump_act = detect.pump_uv && !puv_off;
    // latch and retry modes stop drivers; report does not
    assign oc_stop = oc_st_q && (oc_mode != OC_REPORT);
    assign fault_now = detect.supply_uv || detect.supply_ov ||
                       detect.pump_uv || oc_st_q || !detect.rails_ready;

    // Power sequencing is registered so every output comes from a flop.
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            power <= '0;
            shutdown_mode <= 1'b1;
            fault_indicator_n_o <= 1'b0;
            fault_indicator_n_oe <= 1'b1;
            pump_buck_hiz <= 1'b0;
        end
        else
        begin
            fault_indicator_n_o <= 1'b0;
            fault_indicator_n_oe <= fault_now;
            shutdown_mode <= detect.logic_supply_undervoltage;
            // release high-Z once the drive rail is back
            pump_buck_hiz <= detect.drive_rail_overvoltage;
            // shutdown keeps only regulators 1 and 3
            if (detect.logic_supply_undervoltage)
            begin
                power <= '0;
                power.lin1_en <= 1'b1;
                power.lin3_en <= 1'b1;
            end
            else
            begin
                power.lin1_en <= !pump_act;
                power.lin3_en <= 1'b1;
                power.buck_en <= !(sup_uv_act || sup_ov_act) &&
                                 !rail_ov_seen_q;
                power.pump_en <= !(sup_uv_act || sup_ov_act) &&
                                 !rail_ov_seen_q;
                power.lin2_en <= !(sup_uv_act || sup_ov_act);
                power.drv_en <= !(sup_uv_act || sup_ov_act || pump_act ||
                                  drv_hold_q || oc_stop);
                power.drv_pull_low <= oc_stop && pull_low_sel;
            end
        end
    end

    // Readback views.
    assign status_w = {16'h0000, 2'b00, fet_st_q, 3'b000, oc_st_q,
                       puv_st_q, ov_st_q, uv_st_q,
                       uv_st_q | ov_st_q | puv_st_q | oc_st_q};
    assign raw_w = {20'h0_0000, th_sel, 2'b00, oc_hit};
    assign outs_w = {23'h00_0000, pump_buck_hiz, shutdown_mode,
                     fault_indicator_n_oe, power.drv_en, power.buck_en,
                     power.pump_en, power.lin1_en, power.lin2_en,
                     power.lin3_en};

endmodule : gdf_fault_manager

// ---- inc/gdf_pkg.sv ----
package gdf_pkg;

    // ****************************************************************
    // Register map (word byte addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_RAW = 4'h8;
    localparam logic [3:0] ADDR_OUTS = 4'hc;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_CLR_BIT = 0;
    localparam int CTRL_UVOFF_BIT = 1;
    localparam int CTRL_OVOFF_BIT = 2;
    localparam int CTRL_PUVOFF_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_PD_BIT = 6;
    localparam int CTRL_TH_LSB = 8;
    localparam int CTRL_DEG_LSB = 12;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ****************************************************************
    // Status register fields
    // ****************************************************************
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_UV_BIT = 1;
    localparam int ST_OV_BIT = 2;
    localparam int ST_PUV_BIT = 3;
    localparam int ST_OC_BIT = 4;
    localparam int ST_FET_LSB = 8;
    localparam int NUM_FETS = 6;

    // ****************************************************************
    // Overcurrent response modes
    // ****************************************************************
    typedef enum logic [1:0] {
        OC_LATCH = 2'b00,
        OC_RETRY = 2'b01,
        OC_REPORT = 2'b10,
        OC_IGNORE = 2'b11
    } gdf_oc_mode_type;

    // Retry controller states.
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_HOLD = 2'b01,
        RS_WAIT = 2'b10
    } gdf_retry_state_type;

    // Regulator and driver enables travel together.
    typedef struct packed {
        logic drv_en;
        logic drv_pull_low;
        logic buck_en;
        logic pump_en;
        logic lin1_en;
        logic lin2_en;
        logic lin3_en;
    } gdf_power_type;

    // Raw detector inputs travel together.
    typedef struct packed {
        logic logic_supply_undervoltage;
        logic supply_uv;
        logic supply_ov;
        logic pump_uv;
        logic drive_rail_overvoltage;
        logic rails_ready;
    } gdf_detect_type;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLOCK_MHZ = 250;
    localparam int RETRY_US = 4000;
    localparam int RETRY_CYCLES = RETRY_US * CLOCK_MHZ;
    localparam int DEG_STEP_NS = 1000;
    localparam int DEG_STEP_CYCLES = DEG_STEP_NS * CLOCK_MHZ / 1000;
    localparam logic [1:0] BUS_OK = 2'b00;

endpackage : gdf_pkg

// ---- verification/gate_driver_fault_manager_tb.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Fault manager testbench
// ****************************************************************
module gate_driver_fault_manager_tb;
    import gdf_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    gdf_detect_type detect = 6'h01;
    logic [5:0] fet_on = 6'h00;
    logic [5:0] fet_vds_level = 6'h00;
    logic enable_pin;
    logic line_o;
    logic line_oe;
    wire fault_line_n;
    logic shutdown_mode;
    gdf_power_type power;
    logic pump_buck_hiz;
    logic pulse_req = 1'b0;
    int failures = 0;
    int comparisons = 0;

    // The line has a pull-up, so it reads high unless it is sunk.
    assign fault_line_n = line_oe ? line_o : 1'b1;
    always #2 clock = ~clock;

    gdf_fault_manager #(.RETRY_COUNT(20), .DEG_UNIT(2)) u_dut (
        .clock(clock), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .detect(detect), .fet_on(fet_on), .fet_vds_level(fet_vds_level),
        .enable_pin(enable_pin), .fault_indicator_n_o(line_o),
        .fault_indicator_n_oe(line_oe), .shutdown_mode(shutdown_mode),
        .power(power), .pump_buck_hiz(pump_buck_hiz)
    );
    gdf_mcu_model #(.LOW_CYCLES(3)) u_mcu (
        .clock(clock), .fault_line_n(fault_line_n), .pulse_req(pulse_req),
        .enable_pin(enable_pin), .fault_seen()
    );

    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // Values read right after the edge are the ones that edge sampled.
    task automatic bus_op(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            failures++;
            wrap_up();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus_op

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_op(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic clr_cmd(input logic [31:0] ctrl);
        logic [31:0] q;
        bus_op(1'b1, ADDR_CTRL, ctrl | 32'h1, q);
        tick(2);
    endtask : clr_cmd

    task automatic en_pulse;
        pulse_req <= 1'b1;
        tick(1);
        pulse_req <= 1'b0;
        tick(7);
    endtask : en_pulse

    task automatic t_reset;
        logic [31:0] q;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_STATUS, 32'h0);
        bus_op(1'b1, 4'h2, 32'hffff_ffff, q);
        rd(4'h2, 32'h0);
        rd(ADDR_CTRL, CTRL_RESET);
        chk({31'h0, fault_line_n}, 32'h1);
    endtask : t_reset

    // One supply fault raised, removed, then cleared by command or pin.
    task automatic t_rail_fault(input int b, input logic [31:0] pw_on,
        input logic [31:0] pw_off, input logic [31:0] st, input logic use_en);
        detect[b] <= 1'b1;
        tick(3);
        chk({31'h0, fault_line_n}, 32'h0);
        chk({25'h0, power}, pw_on);
        detect[b] <= 1'b0;
        tick(3);
        chk({31'h0, fault_line_n}, 32'h1);
        chk({25'h0, power}, pw_off);
        rd(ADDR_STATUS, st);
        if (use_en)
            en_pulse();
        else
            clr_cmd(32'h0);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_CTRL, 32'h0);
        chk({25'h0, power}, 32'h5f);
    endtask : t_rail_fault

    task automatic t_detect_off;
        logic [31:0] q;
        bus_op(1'b1, ADDR_CTRL, 32'he, q);
        for (int b = 4; b >= 2; b--)
        begin
            detect[b] <= 1'b1;
            tick(3);
            chk({31'h0, fault_line_n}, 32'h0);
            chk({25'h0, power}, 32'h5f);
            detect[b] <= 1'b0;
            tick(3);
            chk({31'h0, fault_line_n}, 32'h1);
            rd(ADDR_STATUS, 32'h1 | (32'h1 << (5 - b)));
            clr_cmd(32'he);
            rd(ADDR_STATUS, 32'h0);
        end
        bus_op(1'b1, ADDR_CTRL, 32'h0, q);
    endtask : t_detect_off

    task automatic t_logic_uv;
        detect.logic_supply_undervoltage <= 1'b1;
        tick(3);
        chk({31'h0, shutdown_mode}, 32'h1);
        chk({25'h0, power}, 32'h05);
        detect.logic_supply_undervoltage <= 1'b0;
        tick(3);
        chk({31'h0, shutdown_mode}, 32'h0);
    endtask : t_logic_uv

    task automatic t_rails_drive;
        detect.rails_ready <= 1'b0;
        tick(3);
        chk({31'h0, fault_line_n}, 32'h0);
        detect.rails_ready <= 1'b1;
        detect.drive_rail_overvoltage <= 1'b1;
        tick(3);
        chk({31'h0, pump_buck_hiz}, 32'h1);
        detect.drive_rail_overvoltage <= 1'b0;
        tick(3);
        chk({31'h0, pump_buck_hiz}, 32'h0);
        clr_cmd(32'h0);
    endtask : t_rails_drive

    // Overcurrent on FET 2, pulldown selected, under one response mode.
    task automatic t_overcurrent(input logic [1:0] m);
        logic [31:0] q;
        int n;
        bus_op(1'b1, ADDR_CTRL, 32'h40 | ({30'h0, m} << 4), q);
        fet_vds_level <= 6'h04;
        tick(8);
        fet_on <= 6'h04;
        tick(1);
        fet_vds_level <= 6'h00;
        tick(4);
        rd(ADDR_STATUS, 32'h0);
        fet_vds_level <= 6'h04;
        tick(8);
        if (m == OC_REPORT)
        begin
            clr_cmd(32'h60);
            rd(ADDR_STATUS, 32'h411);
            chk({31'h0, power.drv_en}, 32'h1);
        end
        fet_vds_level <= 6'h00;
        tick(3);
        if (m == OC_IGNORE)
        begin
            chk({31'h0, fault_line_n}, 32'h1);
            rd(ADDR_STATUS, 32'h0);
        end
        else if (m == OC_RETRY)
        begin
            n = 0;
            while (fault_line_n !== 1'b1 && n < 60)
            begin
                tick(1);
                n++;
            end
            chk({31'h0, fault_line_n}, 32'h1);
            rd(ADDR_STATUS, 32'h0);
            chk({31'h0, power.drv_en}, 32'h1);
        end
        else
        begin
            chk({31'h0, fault_line_n}, 32'h0);
            rd(ADDR_STATUS, 32'h411);
            if (m == OC_LATCH)
                chk({30'h0, power[6:5]}, 32'h1);
            en_pulse();
            chk({31'h0, fault_line_n}, 32'h1);
            rd(ADDR_STATUS, 32'h0);
        end
        fet_on <= 6'h00;
        tick(2);
    endtask : t_overcurrent

    initial
    begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        tick(6);
        t_reset();
        t_rail_fault(4, 32'h05, 32'h5f, 32'h3, 1'b0);
        t_rail_fault(3, 32'h05, 32'h1f, 32'h5, 1'b1);
        t_rail_fault(2, 32'h1b, 32'h1f, 32'h9, 1'b0);
        t_detect_off();
        t_logic_uv();
        t_rails_drive();
        for (int m = 0; m < 4; m++)
            t_overcurrent(m[1:0]);
        wrap_up();
    end
endmodule : gate_driver_fault_manager_tb

// ---- verification/gdf_fault_manager_chk.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the fault manager
// ****************************************************************
module gdf_chk
    import gdf_pkg::*;
#(
    parameter int RETRY_COUNT = 20,
    parameter int DEG_UNIT = 2
)(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire gdf_pkg::gdf_detect_type detect,
    input wire logic [5:0] fet_on,
    input wire logic [5:0] fet_vds_level,
    input wire logic enable_pin,
    input wire logic fault_indicator_n_o,
    input wire logic fault_indicator_n_oe,
    input wire logic shutdown_mode,
    input wire gdf_pkg::gdf_power_type power,
    input wire logic pump_buck_hiz
);
    logic [31:0] ctrl_q;
    logic [3:0] live_q;
    logic live;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // Shadow of the control word, so detector enables are known here.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            ctrl_q <= CTRL_RESET;
        else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL)
            ctrl_q <= avs_writedata;
    end

    // The inner reset copy lags, so outputs are judged a few edges later.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            live_q <= 4'h0;
        else
            live_q <= {live_q[2:0], 1'b1};
    end
    assign live = live_q[3];

    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest && avs_response == BUS_OK ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (live ##0 s_taken |=> s_answer)
        else $error("bus answer missing or too long");
    a_clear_reads_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == ADDR_CTRL
        |-> avs_readdata[CTRL_CLR_BIT] == 1'b0)
        else $error("clear bit read back as one");
    a_fault_line_low: assert property (
        live && (detect.supply_uv || detect.supply_ov || detect.pump_uv)
        |=> fault_indicator_n_oe && !fault_indicator_n_o)
        else $error("fault line not pulled low");
    a_rails_hold_line: assert property (
        live && !detect.rails_ready |=> fault_indicator_n_oe)
        else $error("fault line released before rails up");
    a_uv_power_off: assert property (
        live && detect.supply_uv && !ctrl_q[CTRL_UVOFF_BIT] && !detect.pump_uv
        |=> !power.drv_en && !power.buck_en && !power.pump_en
            && !power.lin2_en && power.lin1_en && power.lin3_en)
        else $error("supply undervoltage power state wrong");
    a_ov_power_off: assert property (
        live && detect.supply_ov && !ctrl_q[CTRL_OVOFF_BIT] && !detect.pump_uv
        |=> !power.drv_en && !power.buck_en && !power.pump_en
            && !power.lin2_en && power.lin1_en && power.lin3_en)
        else $error("supply overvoltage power state wrong");
    a_pump_first_linear_regulator_off: assert property (
        live && detect.pump_uv && !ctrl_q[CTRL_PUVOFF_BIT]
        && !detect.supply_uv && !detect.supply_ov
        && !detect.logic_supply_undervoltage
        |=> !power.drv_en && !power.lin1_en && power.buck_en
            && power.pump_en && power.lin2_en && power.lin3_en)
        else $error("pump undervoltage power state wrong");
    a_shutdown_entry: assert property (
        live && detect.logic_supply_undervoltage
        |=> shutdown_mode && !power.drv_en && power.lin1_en && power.lin3_en)
        else $error("logic supply undervoltage without shutdown");
    a_hiz_release: assert property (
        live && $fell(detect.drive_rail_overvoltage)
        |-> ##[1:3] !pump_buck_hiz)
        else $error("pump and buck kept high impedance");
endmodule : gdf_chk

bind gdf_fault_manager gdf_chk #(
    .RETRY_COUNT(RETRY_COUNT),
    .DEG_UNIT(DEG_UNIT)
) u_chk (
    .clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .detect(detect), .fet_on(fet_on), .fet_vds_level(fet_vds_level),
    .enable_pin(enable_pin), .fault_indicator_n_o(fault_indicator_n_o),
    .fault_indicator_n_oe(fault_indicator_n_oe),
    .shutdown_mode(shutdown_mode), .power(power),
    .pump_buck_hiz(pump_buck_hiz)
);

// ---- verification/gdf_mcu_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Controller model on the far side of the fault line
// ****************************************************************
module gdf_mcu_model #(
    parameter int LOW_CYCLES = 3
)(
    input wire logic clock,
    input wire logic fault_line_n,
    input wire logic pulse_req,
    output logic enable_pin,
    output logic fault_seen
);
    int low_cnt = 0;

    initial enable_pin = 1'b1;

    // enable low pulse
    // A request gives one low pulse; its rising end is the clear.
    always @(posedge clock)
    begin
        if (pulse_req && low_cnt == 0)
        begin
            enable_pin <= 1'b0;
            low_cnt <= LOW_CYCLES;
        end
        else if (low_cnt == 1)
        begin
            enable_pin <= 1'b1;
            low_cnt <= 0;
        end
        else if (low_cnt > 1)
            low_cnt <= low_cnt - 1;
    end

    // The line is only watched; handling is left to the bench.
    assign fault_seen = !fault_line_n;
endmodule : gdf_mcu_model
